// >>> hw/power_mgmt_capability_regs.sv
// Power management capability registers behind an AXI4-Lite slave
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps

module power_mgmt_capability_regs (
   // Clock and resets
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic                         hot_reset,
   // Port role and lock
   input  wire logic                         upstream_port,
   input  wire logic                         lockable_write_unlock,
   input  wire logic                         cold_off,
   // Wake events
   input  wire logic                         own_wake_event,
   input  wire logic                         relayed_wake_event,
   output logic                              wake_message,
   output logic                              power_state_hot_off,
   output logic                              irq,
   // AXI4-Lite write address
   input  wire logic [pm_cap_pkg::addr_width-1:0] s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [pm_cap_pkg::addr_width-1:0] s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready
);

   // Captured write address and data
   logic [pm_cap_pkg::addr_width-1:0] waddr;
   logic                              waddr_held;
   logic [31:0]                       wdata;
   logic [3:0]                        wstrb;
   logic                              wdata_held;

   // Register state
   logic [7:0]  next_capability_link;
   logic        special_init_required;
   logic [4:0]  wake_event_support;
   logic [1:0]  power_state_field;
   logic        context_preserved_flag;
   logic        wake_enable;
   logic        wake_status;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        role_caught;
   logic        upstream_seen;

   // Decoded mode for the wake logic
   pm_cap_pkg::power_mode_type power_mode;

   // Write decode
   wire [11:0] widx          = waddr[pm_cap_pkg::addr_width-1:2];
   wire        do_write      = waddr_held && wdata_held && !s_axi_bvalid;
   wire        wr_capability = do_write && widx == pm_cap_pkg::idx_power_capability;
   wire        wr_control    = do_write && widx == pm_cap_pkg::idx_power_control;
   wire        wr_irq_status = do_write && widx == pm_cap_pkg::idx_irq_status;
   wire        wr_irq_mask   = do_write && widx == pm_cap_pkg::idx_irq_mask;
   wire        wr_reserved   = do_write && (widx == pm_cap_pkg::idx_link_status_two ||
                                            widx == pm_cap_pkg::idx_slot_caps_two ||
                                            widx == pm_cap_pkg::idx_slot_control_two ||
                                            widx == pm_cap_pkg::idx_slot_status_two);
   wire        wr_port_info  = do_write && widx == pm_cap_pkg::idx_port_info;
   wire        wr_mapped     = wr_capability || wr_control || wr_irq_status || wr_irq_mask ||
                               wr_reserved || wr_port_info;

   // Lockable fields take writes only when unlocked
   wire        lock_open     = lockable_write_unlock;

   // Strap until the role is caught
   wire        upstream_role = role_caught ? upstream_seen : upstream_port;

   // Power state accepts only the two supported codes; reserved codes are dropped
   wire [1:0]  new_state     = wdata[pm_cap_pkg::pos_power_state +: 2];
   wire        state_ok      = new_state == pm_cap_pkg::state_fully_on ||
                               new_state == pm_cap_pkg::state_hot_off;
   wire        state_write   = wr_control && wstrb[0] && state_ok;

   // Own wake events set status unless the port was caught as upstream; relays never do
   wire        own_event     = own_wake_event && !upstream_seen;
   wire        clear_status  = wr_control && wstrb[1] && wdata[pm_cap_pkg::pos_wake_status];

   // Wake messages need enable and a non-cold state
   wire        wake_allowed  = wake_enable && power_mode != pm_cap_pkg::pwr_cold_off;
   wire        next_wake_msg = wake_allowed && (own_event || relayed_wake_event);

   // Capability word assembly
   wire [31:0] capability_word = {wake_event_support,
                                  2'h0,
                                  3'h0,
                                  special_init_required,
                                  2'h0,
                                  pm_cap_pkg::capability_version_value,
                                  next_capability_link,
                                  pm_cap_pkg::capability_identifier_value};

   // Control/status word assembly, unimplemented data fields are zero
   wire [31:0] control_word = {8'h00, 8'h00,
                               wake_status, 2'h0, 4'h0, wake_enable,
                               4'h0, context_preserved_flag, 1'b0, power_state_field};

   // Read decode
   wire [11:0] ridx = s_axi_araddr[pm_cap_pkg::addr_width-1:2];
   wire        rd_reserved = ridx == pm_cap_pkg::idx_link_status_two ||
                             ridx == pm_cap_pkg::idx_slot_caps_two ||
                             ridx == pm_cap_pkg::idx_slot_control_two ||
                             ridx == pm_cap_pkg::idx_slot_status_two;
   // Read data select
   pm_cap_pkg::read_answer_type next_answer;
   always_comb begin
      next_answer.resp = pm_cap_pkg::resp_okay;
      unique case (ridx)
         pm_cap_pkg::idx_power_capability: next_answer.data = capability_word;
         pm_cap_pkg::idx_power_control:    next_answer.data = control_word;
         pm_cap_pkg::idx_irq_status:       next_answer.data = {30'h0, irq_status};
         pm_cap_pkg::idx_irq_mask:         next_answer.data = {30'h0, irq_mask};
         pm_cap_pkg::idx_port_info:        next_answer.data = {30'h0, wake_allowed, upstream_seen};
         default: begin
            next_answer.data = 32'h0;
            if (!rd_reserved) begin
               next_answer.resp = pm_cap_pkg::resp_slverr;
            end
         end
      endcase
   end

   // Power mode derived from the state field and the cold-off indication
   assign power_mode = cold_off ? pm_cap_pkg::pwr_cold_off :
                       (power_state_field == pm_cap_pkg::state_hot_off) ? pm_cap_pkg::pwr_hot_off :
                       pm_cap_pkg::pwr_on;

   // Write address and data channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waddr_held <= 1'b0;
         wdata_held <= 1'b0;
         waddr      <= '0;
         wdata      <= 32'h0;
         wstrb      <= 4'h0;
      end else if (do_write) begin
         // Both slots drain
         waddr_held <= 1'b0;
         wdata_held <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            waddr_held <= 1'b1;
            waddr      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_held <= 1'b1;
            wdata      <= s_axi_wdata;
            wstrb      <= s_axi_wstrb;
         end
      end
   end

   // Ready while the channel slot is empty and no response is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !waddr_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !do_write;
         s_axi_wready  <= !wdata_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !do_write;
      end
   end

   // Write response, unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pm_cap_pkg::resp_okay;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? pm_cap_pkg::resp_okay : pm_cap_pkg::resp_slverr;
      end else if (s_axi_bready) begin
         // Answer taken
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one cycle to answer, held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= pm_cap_pkg::resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_answer.data;
         s_axi_rresp   <= next_answer.resp;
      end else if (s_axi_rvalid) begin
         // Held until taken
         s_axi_rvalid  <= !s_axi_rready;
      end else begin
         // Idle: accept a read
         s_axi_arready <= 1'b1;
      end
   end

   // Port role caught once after reset release, since a strap is not read under reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         role_caught   <= 1'b0;
         upstream_seen <= 1'b0;
      end else if (!role_caught) begin
         // One-shot catch
         role_caught   <= 1'b1;
         upstream_seen <= upstream_port;
      end
   end

   // Lockable capability fields; next link takes its role default
   always_ff @(posedge aclk) begin
      if (!aresetn || hot_reset) begin
         // Hot reset keeps the role default
         next_capability_link  <= upstream_role ? pm_cap_pkg::next_link_upstream
                                                : pm_cap_pkg::next_link_downstream;
         special_init_required <= pm_cap_pkg::special_init_default;
         wake_event_support    <= pm_cap_pkg::wake_support_default;
      end else if (!role_caught) begin
         next_capability_link  <= upstream_port ? pm_cap_pkg::next_link_upstream
                                                : pm_cap_pkg::next_link_downstream;
      end else if (wr_capability && lock_open) begin
         if (wstrb[1]) begin
            next_capability_link <= wdata[pm_cap_pkg::pos_next_link +: 8];
         end
         if (wstrb[2]) begin
            special_init_required <= wdata[pm_cap_pkg::pos_special_init];
         end
         if (wstrb[3]) begin
            wake_event_support <= wdata[pm_cap_pkg::pos_wake_support +: 5];
         end
      end
   end

   // Non-sticky control fields; hot reset restores their defaults
   always_ff @(posedge aclk) begin
      if (!aresetn || hot_reset) begin
         power_state_field      <= pm_cap_pkg::state_fully_on;
         context_preserved_flag <= pm_cap_pkg::context_preserved_default;
      end else begin
         if (state_write) begin
            power_state_field <= new_state;
         end
         // Lock gates the flag
         if (wr_control && wstrb[0] && lock_open) begin
            context_preserved_flag <= wdata[pm_cap_pkg::pos_context_preserved];
         end
      end
   end

   // Sticky wake bits: of the two resets only the fundamental one clears them, hot reset is ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_enable <= 1'b0;
         wake_status <= 1'b0;
      end else begin
         if (wr_control && wstrb[1]) begin
            wake_enable <= wdata[pm_cap_pkg::pos_wake_enable];
         end
         // Set wins over a same-cycle clear so no event is lost
         if (own_event) begin
            wake_status <= 1'b1;
         end else if (clear_status) begin
            wake_status <= 1'b0;
         end
      end
   end

   // Interrupt status: own wake event and power state change, write one to clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 2'h0;
         irq_mask   <= 2'h0;
      end else begin
         // Set wins over clear
         for (int i = 0; i < 2; i++) begin
            if ((i == pm_cap_pkg::irq_wake_event && own_event) ||
                (i == pm_cap_pkg::irq_state_change && state_write && new_state != power_state_field)) begin
               irq_status[i] <= 1'b1;
            end else if (wr_irq_status && wstrb[0] && wdata[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
         if (wr_irq_mask && wstrb[0]) begin
            irq_mask <= wdata[1:0];
         end
      end
   end

   // Registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq                 <= 1'b0;
         wake_message        <= 1'b0;
         power_state_hot_off <= 1'b0;
      end else begin
         // All one cycle late
         irq                 <= |(irq_status & irq_mask);
         wake_message        <= next_wake_msg;
         power_state_hot_off <= power_mode == pm_cap_pkg::pwr_hot_off;
      end
   end

endmodule : power_mgmt_capability_regs

// >>> shared/pm_cap_pkg.sv
// Package with register map, field layout and defaults of the power management capability block
package pm_cap_pkg;

   // Printed offsets are not all multiples of four: they are indices, byte address is index times four
   localparam logic [11:0] idx_link_status_two    = 12'h072;
   localparam logic [11:0] idx_slot_caps_two      = 12'h074;
   localparam logic [11:0] idx_slot_control_two   = 12'h078;
   localparam logic [11:0] idx_slot_status_two    = 12'h07a;
   localparam logic [11:0] idx_power_capability   = 12'h0c0;
   localparam logic [11:0] idx_power_control      = 12'h0c4;
   // Own registers for interrupts, port role and wake permission
   localparam logic [11:0] idx_irq_status         = 12'h100;
   localparam logic [11:0] idx_irq_mask           = 12'h101;
   localparam logic [11:0] idx_port_info          = 12'h102;
   localparam int          addr_width             = 14;

   // Capability word fields
   localparam logic [7:0]  capability_identifier_value = 8'h01;
   localparam logic [7:0]  next_link_upstream          = 8'h00;
   localparam logic [7:0]  next_link_downstream        = 8'hd0;
   localparam logic [2:0]  capability_version_value    = 3'h3;
   localparam logic        special_init_default        = 1'b0;
   localparam logic [4:0]  wake_support_default        = 5'h19;
   localparam int          pos_next_link               = 8;
   localparam int          pos_version                 = 16;
   localparam int          pos_special_init            = 21;
   localparam int          pos_wake_support            = 27;

   // Control/status word fields
   localparam int          pos_power_state             = 0;
   localparam int          pos_context_preserved       = 3;
   localparam int          pos_wake_enable             = 8;
   localparam int          pos_wake_status             = 15;
   localparam logic [1:0]  state_fully_on              = 2'h0;
   localparam logic [1:0]  state_hot_off               = 2'h3;
   localparam logic        context_preserved_default   = 1'b1;

   // Interrupt status bits
   localparam int          irq_wake_event              = 0;
   localparam int          irq_state_change            = 1;

   // AXI responses
   localparam logic [1:0]  resp_okay                   = 2'h0;
   localparam logic [1:0]  resp_slverr                 = 2'h2;

   // Power states seen by the wake logic
   typedef enum logic [1:0] {pwr_on, pwr_hot_off, pwr_cold_off} power_mode_type;

   // Read answer carrier
   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  resp;
   } read_answer_type;

endpackage : pm_cap_pkg

// >>> sim/power_mgmt_capability_regs_asserts.sv
// Checker for the power management register block, bound to its ports
`timescale 1ns/1ps
module power_mgmt_capability_regs_asserts (
   // Clock and resets
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        hot_reset,
   // Role and wake side
   input wire logic        upstream_port,
   input wire logic        cold_off,
   input wire logic        own_wake_event,
   input wire logic        relayed_wake_event,
   input wire logic        wake_message,
   input wire logic        power_state_hot_off,
   // Bus signals watched
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic [13:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid
);
   logic [11:0] read_index; // Index of the read in flight
   // Remember which register the pending read answers for
   always_ff @(posedge aclk) begin
      if (!aresetn) read_index <= 12'h000;
      else if (s_axi_arvalid && s_axi_arready) read_index <= s_axi_araddr[13:2];
   end
   wire rsv_rd = (read_index == 12'h072) || (read_index == 12'h074) || (read_index == 12'h078) ||
                 (read_index == 12'h07a);
   wire cap_rd = s_axi_rvalid && (read_index == 12'h0c0); // Capability word answer
   wire ctl_rd = s_axi_rvalid && (read_index == 12'h0c4); // Control word answer
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A hot reset with no write in its shadow, so nothing can re-enter hot-off
   sequence s_quiet_hot_reset;
      hot_reset && !$past(s_axi_awvalid) && !$past(s_axi_wvalid);
   endsequence
   property p_rsv_zero;
      s_axi_rvalid && rsv_rd |-> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
   property p_cap_id;
      cap_rd |-> s_axi_rdata[7:0] == 8'h01;
   endproperty
   a_cap_id: assert property (p_cap_id) else $error("identifier wrong");
   property p_cap_ver;
      cap_rd |-> s_axi_rdata[18:16] == 3'h3;
   endproperty
   a_cap_ver: assert property (p_cap_ver) else $error("version wrong");
   property p_no_mid_states;
      cap_rd |-> s_axi_rdata[26:25] == 2'h0;
   endproperty
   a_no_mid_states: assert property (p_no_mid_states) else $error("state support set");
   property p_ctl_unimpl;
      ctl_rd |-> s_axi_rdata[14:9] == 6'h00 && s_axi_rdata[31:24] == 8'h00;
   endproperty
   a_ctl_unimpl: assert property (p_ctl_unimpl) else $error("data fields not zero");
   property p_up_status;
      ctl_rd && upstream_port |-> !s_axi_rdata[15];
   endproperty
   a_up_status: assert property (p_up_status) else $error("upstream status set");
   property p_cold_block;
      wake_message |-> !$past(cold_off);
   endproperty
   a_cold_block: assert property (p_cold_block) else $error("message in cold off");
   property p_msg_cause;
      wake_message |-> $past(own_wake_event || relayed_wake_event);
   endproperty
   a_msg_cause: assert property (p_msg_cause) else $error("message without event");
   property p_hot_reset_on;
      s_quiet_hot_reset |=> ##1 !power_state_hot_off;
   endproperty
   a_hot_reset_on: assert property (p_hot_reset_on) else $error("hot-off after hot reset");
endmodule : power_mgmt_capability_regs_asserts
bind power_mgmt_capability_regs power_mgmt_capability_regs_asserts u_power_mgmt_capability_regs_asserts (
   .aclk(aclk), .aresetn(aresetn), .hot_reset(hot_reset), .upstream_port(upstream_port), .cold_off(cold_off),
   .own_wake_event(own_wake_event), .relayed_wake_event(relayed_wake_event), .wake_message(wake_message),
   .power_state_hot_off(power_state_hot_off), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));

// >>> sim/power_mgmt_capability_regs_bench.sv
// Self-checking bench for the power management register block
`timescale 1ns/1ps
module power_mgmt_capability_regs_bench;
   logic        aclk, aresetn, hot_reset, upstream_port, lockable_write_unlock, cold_off;
   logic        own_wake_event, relayed_wake_event, wake_message, power_state_hot_off, irq;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, last_bresp, pst;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, en;
   int          err_total, samples_checked, i;
   logic [11:0] rsv [4] = '{12'h072, 12'h074, 12'h078, 12'h07a}; // Reserved indices
   power_mgmt_capability_regs u_power_mgmt_capability_regs (
      .aclk(aclk), .aresetn(aresetn), .hot_reset(hot_reset), .upstream_port(upstream_port),
      .lockable_write_unlock(lockable_write_unlock), .cold_off(cold_off), .own_wake_event(own_wake_event),
      .relayed_wake_event(relayed_wake_event), .wake_message(wake_message), .power_state_hot_off(power_state_hot_off),
      .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   // Expected capability word from its writable fields
   function automatic logic [31:0] cap_word(input logic [7:0] link, input logic sp, input logic [4:0] ws);
      return {ws, 5'h00, sp, 2'h0, 3'h3, link, 8'h01};
   endfunction : cap_word
   // Expected control word from state, preserved flag, enable and status
   function automatic logic [31:0] ctrl_word(input logic [1:0] st, input logic ctx, input logic e, input logic ws);
      return {16'h0000, ws, 6'h00, e, 4'h0, ctx, 1'b0, st};
   endfunction : ctrl_word
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // A handshake that never came ends the run
   task automatic guard(input logic stuck);
      if (stuck) begin
         err_total++;
         $display("mismatch handshake expected done seen timeout");
         end_of_test();
      end
   endtask : guard
   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] idx, input logic [31:0] v);
      logic aw_open, w_open;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {idx, 2'b00, v, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      {aw_open, w_open} = 2'b11;
      for (int n = 0; n < 40 && (aw_open || w_open); n++) begin
         @(posedge aclk);
         if (aw_open && s_axi_awready === 1'b1) begin aw_open = 1'b0; s_axi_awvalid <= 1'b0; end
         if (w_open && s_axi_wready === 1'b1) begin w_open = 1'b0; s_axi_wvalid <= 1'b0; end
      end
      guard(aw_open || w_open);
      for (int n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++) @(posedge aclk);
      guard(s_axi_bvalid !== 1'b1);
      last_bresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // Read and compare data and response
   task automatic rchk(input logic [11:0] idx, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      @(posedge aclk);
      for (int n = 0; n < 40 && s_axi_arready !== 1'b1; n++) @(posedge aclk);
      guard(s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      for (int n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid === 1'b1) break;
      end
      guard(s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk($sformatf("data %h", idx), e, s_axi_rdata);
      chk($sformatf("resp %h", idx), {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : rchk
   // One-cycle wake event, then its message check
   task automatic pulse(input logic own, input logic e);
      @(posedge aclk);
      {own_wake_event, relayed_wake_event} <= {own, ~own};
      @(posedge aclk);
      {own_wake_event, relayed_wake_event} <= 2'b00;
      #1;
      chk("wake_message", {31'h0, e}, {31'h0, wake_message});
   endtask : pulse
   // The interrupt level lags its cause, so let it settle first
   task automatic irq_is(input logic e);
      repeat (3) @(posedge aclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : irq_is
   initial begin
      {aresetn, hot_reset, upstream_port, lockable_write_unlock, cold_off, own_wake_event} = 6'h00;
      {relayed_wake_event, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {err_total, samples_checked, seed} = {32'd0, 32'd0, 32'h1721};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(12'h0c0, cap_word(8'hd0, 1'b0, 5'h19), 2'h0);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b0, 1'b0), 2'h0);
      rchk(12'h050, 32'h0, 2'h2);
      wr(12'h050, 32'hffffffff);
      chk("unmapped bresp", 32'h2, {30'h0, last_bresp});
      $display("defaults test done");
      // Random writes with the lock closed; every state code is tried
      {pst, en} = 3'b000;
      for (i = 0; i < 8; i++) begin
         seed = xs(seed);
         d = {seed[31:2], i[1:0]};
         wr(rsv[i % 4], d);
         rchk(rsv[i % 4], 32'h0, 2'h0);
         wr(12'h0c0, d);
         rchk(12'h0c0, cap_word(8'hd0, 1'b0, 5'h19), 2'h0);
         wr(12'h0c4, d);
         if (d[1:0] == 2'h0 || d[1:0] == 2'h3) pst = d[1:0];
         en = d[8];
         rchk(12'h0c4, ctrl_word(pst, 1'b1, en, 1'b0), 2'h0);
      end
      $display("random test done");
      wr(12'h0c4, 32'h100);
      wr(12'h100, 32'h3);
      wr(12'h101, 32'h1);
      irq_is(1'b0);
      pulse(1'b1, 1'b1);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b1, 1'b1), 2'h0);
      irq_is(1'b1);
      wr(12'h101, 32'h0);
      irq_is(1'b0);
      wr(12'h101, 32'h1);
      irq_is(1'b1);
      wr(12'h100, 32'h1);
      irq_is(1'b0);
      wr(12'h0c4, 32'h8100);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b1, 1'b0), 2'h0);
      pulse(1'b0, 1'b1);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b1, 1'b0), 2'h0);
      cold_off <= 1'b1;
      pulse(1'b1, 1'b0);
      @(posedge aclk);
      cold_off <= 1'b0;
      wr(12'h0c4, 32'h8000);
      pulse(1'b1, 1'b0);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b0, 1'b1), 2'h0);
      $display("wake test done");
      lockable_write_unlock <= 1'b1;
      wr(12'h0c0, 32'h0);
      rchk(12'h0c0, cap_word(8'h00, 1'b0, 5'h00), 2'h0);
      wr(12'h0c0, 32'h00200000);
      rchk(12'h0c0, cap_word(8'h00, 1'b1, 5'h00), 2'h0);
      wr(12'h0c4, 32'h8103);
      rchk(12'h0c4, ctrl_word(2'h3, 1'b0, 1'b1, 1'b0), 2'h0);
      irq_is(1'b1);
      chk("hot_off", 32'h1, {31'h0, power_state_hot_off});
      hot_reset <= 1'b1;
      @(posedge aclk);
      {hot_reset, lockable_write_unlock} <= 2'b00;
      rchk(12'h0c0, cap_word(8'hd0, 1'b0, 5'h19), 2'h0);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b1, 1'b0), 2'h0);
      chk("hot_off", 32'h0, {31'h0, power_state_hot_off});
      $display("hot reset test done");
      {aresetn, upstream_port} <= 2'b01;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(12'h0c0, cap_word(8'h00, 1'b0, 5'h19), 2'h0);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b0, 1'b0), 2'h0);
      wr(12'h0c4, 32'h100);
      pulse(1'b1, 1'b0);
      rchk(12'h0c4, ctrl_word(2'h0, 1'b1, 1'b1, 1'b0), 2'h0);
      $display("upstream test done");
      end_of_test();
   end
endmodule : power_mgmt_capability_regs_bench
